/* File: qhbp_pkg.sv */
// shared types and constants of the quad uart host bus port
package qhbp_pkg;
  localparam int CHAN_NUM = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 2;

  // values held by the port registers after reset
  localparam logic STROBE_IDLE_RST = 1'b1;
  localparam logic [CHAN_NUM-1:0] SELECT_IDLE_RST = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic OE_OFF_RST = 1'b1;
  localparam logic [CHAN_NUM-1:0] IRQ_OE_RST = 4'hF;
  localparam logic [CHAN_NUM-1:0] IRQ_LVL_RST = 4'h0;

  // channel codes, A through D
  localparam logic [CHAN_W-1:0] CHAN_A = 2'h0;
  localparam logic [CHAN_W-1:0] CHAN_B = 2'h1;
  localparam logic [CHAN_W-1:0] CHAN_C = 2'h2;
  localparam logic [CHAN_W-1:0] CHAN_D = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } qhbp_state_t;

  // one register access handed to the channel register files
  typedef struct packed {
    logic write;
    logic [CHAN_W-1:0] chan;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } qhbp_access_t;

  localparam qhbp_access_t ACCESS_RST = '0;
endpackage

/* File: qhbp_host_port.sv */
// host bus front end of a four channel uart: two bus personalities
`timescale 1ns/1ps
module qhbp_host_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busModeStrobe,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic chanASelectN,
  input wire logic chanBSelectN,
  input wire logic chanCSelectN,
  input wire logic chanDSelectN,
  input wire logic [qhbp_pkg::ADDR_W-1:0] addr,
  input wire logic [qhbp_pkg::DATA_W-1:0] hostWrData,
  output logic [qhbp_pkg::DATA_W-1:0] hostRdData,
  output logic dataOeB,
  input wire logic irqForceEnable,
  input wire logic [qhbp_pkg::CHAN_NUM-1:0] modemCtrlIrqEn,
  input wire logic [qhbp_pkg::CHAN_NUM-1:0] chanIrqPending,
  output logic [qhbp_pkg::CHAN_NUM-1:0] chanIrq,
  output logic [qhbp_pkg::CHAN_NUM-1:0] chanIrqOeB,
  output qhbp_pkg::qhbp_access_t regAccess,
  output logic regRdPulse,
  output logic regWrPulse,
  input wire logic [qhbp_pkg::DATA_W-1:0] regRdData
);
  import qhbp_pkg::*;

  qhbp_state_t state_q, state_d;
  logic rdPrev_q, rdPrev_d;
  logic wrPrev_q, wrPrev_d;
  logic [CHAN_NUM-1:0] selPrev_q, selPrev_d;
  logic [ADDR_W-1:0] addrPrev_q, addrPrev_d;
  logic [DATA_W-1:0] dataPrev_q, dataPrev_d;
  logic [DATA_W-1:0] dataOut_q, dataOut_d;
  logic dataOeB_q, dataOeB_d;
  qhbp_access_t access_q, access_d;
  logic rdPulse_q, rdPulse_d;
  logic wrPulse_q, wrPulse_d;
  logic [CHAN_NUM-1:0] irq_q, irq_d;
  logic [CHAN_NUM-1:0] irqOeB_q, irqOeB_d;

  logic [CHAN_NUM-1:0] selNow;
  logic rdFall, wrFall, csFall, selOne, endAccess;
  logic [CHAN_W-1:0] strobeChan;

  assign selNow = {chanDSelectN, chanCSelectN, chanBSelectN, chanASelectN};
  assign rdFall = rdPrev_q & ~readStrobeN;
  assign wrFall = wrPrev_q & ~writeStrobeN;
  assign csFall = selPrev_q[0] & ~chanASelectN;

  // strobe mode: exactly one channel select low picks the channel
  always_comb begin
    selOne = 1'b1;
    strobeChan = CHAN_A;
    case (~selNow)
      4'h1: strobeChan = CHAN_A;
      4'h2: strobeChan = CHAN_B;
      4'h4: strobeChan = CHAN_C;
      4'h8: strobeChan = CHAN_D;
      default: selOne = 1'b0;
    endcase
  end

  // end of access: strobe or device select returns high
  assign endAccess = busModeStrobe ?
    ((state_q == ST_READ) ? readStrobeN : writeStrobeN) : chanASelectN;

  // bus access sequencer, next values
  always_comb begin
    state_d = state_q;
    rdPrev_d = readStrobeN;
    wrPrev_d = writeStrobeN;
    selPrev_d = selNow;
    addrPrev_d = addr;
    dataPrev_d = hostWrData;
    dataOut_d = dataOut_q;
    dataOeB_d = dataOeB_q;
    access_d = access_q;
    rdPulse_d = 1'b0;
    wrPulse_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        dataOeB_d = OE_OFF_RST;
        if (busModeStrobe) begin
          if (rdFall && selOne) begin
            state_d = ST_READ;
            access_d = '{1'b0, strobeChan, addr, DATA_RST};
            rdPulse_d = 1'b1;
          end else if (wrFall && selOne) begin
            state_d = ST_WRITE;
            access_d.chan = strobeChan;
          end
        end else if (csFall) begin
          access_d.chan = {chanCSelectN, chanBSelectN};
          if (writeStrobeN) begin
            state_d = ST_READ;
            access_d.write = 1'b0;
            access_d.addr = addr;
            access_d.data = DATA_RST;
            rdPulse_d = 1'b1;
          end else begin
            state_d = ST_WRITE;
          end
        end
      end
      ST_READ: begin
        if (endAccess) begin
          state_d = ST_IDLE;
          dataOeB_d = OE_OFF_RST;
        end else begin
          dataOut_d = regRdData;
          dataOeB_d = 1'b0;
        end
      end
      ST_WRITE: begin
        dataOeB_d = OE_OFF_RST;
        if (endAccess) begin
          // data and address sampled while the strobe or device select was still low
          state_d = ST_IDLE;
          access_d.write = 1'b1;
          access_d.addr = addrPrev_q;
          access_d.data = dataPrev_q;
          wrPulse_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        dataOeB_d = OE_OFF_RST;
      end
    endcase
  end

  // interrupt pin drive per channel
  genvar gi;
  generate
    for (gi = 0; gi < CHAN_NUM; gi++) begin : gIrq
      always_comb begin
        if (busModeStrobe) begin
          irq_d[gi] = chanIrqPending[gi];
          irqOeB_d[gi] = ~(modemCtrlIrqEn[gi] | irqForceEnable);
        end else if (gi == 0) begin
          irq_d[gi] = 1'b0;
          irqOeB_d[gi] = ~(|chanIrqPending);
        end else begin
          irq_d[gi] = 1'b0;
          irqOeB_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      rdPrev_q <= STROBE_IDLE_RST;
      wrPrev_q <= STROBE_IDLE_RST;
      selPrev_q <= SELECT_IDLE_RST;
      addrPrev_q <= ADDR_RST;
      dataPrev_q <= DATA_RST;
      dataOut_q <= DATA_RST;
      dataOeB_q <= OE_OFF_RST;
      access_q <= ACCESS_RST;
      rdPulse_q <= 1'b0;
      wrPulse_q <= 1'b0;
      irq_q <= IRQ_LVL_RST;
      irqOeB_q <= IRQ_OE_RST;
    end else begin
      state_q <= state_d;
      rdPrev_q <= rdPrev_d;
      wrPrev_q <= wrPrev_d;
      selPrev_q <= selPrev_d;
      addrPrev_q <= addrPrev_d;
      dataPrev_q <= dataPrev_d;
      dataOut_q <= dataOut_d;
      dataOeB_q <= dataOeB_d;
      access_q <= access_d;
      rdPulse_q <= rdPulse_d;
      wrPulse_q <= wrPulse_d;
      irq_q <= irq_d;
      irqOeB_q <= irqOeB_d;
    end
  end

  assign hostRdData = dataOut_q;
  assign dataOeB = dataOeB_q;
  assign regAccess = access_q;
  assign regRdPulse = rdPulse_q;
  assign regWrPulse = wrPulse_q;
  assign chanIrq = irq_q;
  assign chanIrqOeB = irqOeB_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_read_start: assert property (
    busModeStrobe && state_q == ST_IDLE && rdFall && selOne
    |=> regRdPulse && !regAccess.write && regAccess.addr == $past(addr))
    else $error("strobe read not started");
  chk_read_drive: assert property (
    regRdPulse && !endAccess |=> !dataOeB && hostRdData == $past(regRdData))
    else $error("read data not driven");
  chk_drive_only_read: assert property (
    !dataOeB |-> $past(state_q) == ST_READ)
    else $error("data bus driven outside read");
  chk_write_commit: assert property (
    state_q == ST_WRITE && endAccess
    |=> regWrPulse && regAccess.write && regAccess.data == $past(dataPrev_q))
    else $error("write not committed at strobe rise");
  chk_select_onehot: assert property (
    busModeStrobe && state_q == ST_IDLE && !selOne |=> !regRdPulse)
    else $error("access taken without single select");
  chk_device_select: assert property (
    !busModeStrobe && state_q == ST_IDLE && !csFall
    |=> !regRdPulse && state_q == ST_IDLE)
    else $error("access without device select edge");
  chk_rw_direction: assert property (
    !busModeStrobe && state_q == ST_IDLE && csFall
    |=> state_q == ($past(writeStrobeN) ? ST_READ : ST_WRITE))
    else $error("direction line misread");
  chk_rw_channel: assert property (
    !busModeStrobe && state_q == ST_IDLE && csFall
    |=> regAccess.chan == {$past(chanCSelectN), $past(chanBSelectN)})
    else $error("channel address misdecoded");
  chk_irq_tristate: assert property (
    busModeStrobe && !modemCtrlIrqEn[0] && !irqForceEnable
    |=> chanIrqOeB[0])
    else $error("channel irq driven while disabled");
  chk_irq_force: assert property (
    busModeStrobe && irqForceEnable |=> !chanIrqOeB[1] ##0
    chanIrq[1] == $past(chanIrqPending[1]))
    else $error("force enable ignored");
  chk_irq_opendrain: assert property (
    !busModeStrobe |=> !chanIrq[0] && chanIrqOeB[0] == !$past(|chanIrqPending))
    else $error("device irq wrong");
  chk_irq_unused: assert property (
    !busModeStrobe |=> chanIrq[3:1] == 3'h0 && chanIrqOeB[3:1] == 3'h0)
    else $error("unused irq pins not low");

  cov_strobe_read: cover property (
    busModeStrobe && regRdPulse ##[1:20] state_q == ST_IDLE);
  cov_strobe_write: cover property (busModeStrobe && regWrPulse);
  cov_rw_read: cover property (!busModeStrobe && regRdPulse ##1 !dataOeB);
  cov_rw_write: cover property (!busModeStrobe && regWrPulse);
endmodule

/* File: qhbp_host_model.sv */
// host bus model driving the port pins
`timescale 1ns/1ps
module qhbp_host_model (
  input wire logic clk,
  input wire logic [qhbp_pkg::DATA_W-1:0] hostRdData,
  input wire logic dataOeB,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic [3:0] selN,
  output logic [qhbp_pkg::ADDR_W-1:0] addr,
  output logic [qhbp_pkg::DATA_W-1:0] hostWrData
);
  import qhbp_pkg::*;
  logic [5:0] pins = 6'h3F;
  // pin vector: read, write or direction, selects D to A
  assign {readStrobeN, writeStrobeN, selN} = pins;
  initial addr = ADDR_RST;
  initial hostWrData = DATA_RST;
  // setup, active phase for five edges, release, idle
  task automatic acc(input logic [5:0] su, act, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic oe);
    pins = su;
    addr = a;
    hostWrData = d;
    @(posedge clk) #1 pins = act;
    repeat (4) @(posedge clk);
    #1 q = hostRdData;
    oe = dataOeB;
    @(posedge clk) #1 pins = su;
    repeat (3) @(posedge clk);
    // released lines no longer show the old value
    #1 pins = 6'h3F;
    addr = ~a;
    hostWrData = ~d;
    @(posedge clk) #1;
  endtask
endmodule

/* File: qhbp_host_port_test.sv */
// self-checking bench of the quad uart host bus port
`timescale 1ns/1ps
module qhbp_host_port_test;
  import qhbp_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, busModeStrobe = 1'b1;
  logic irqForce = 1'b0, rdN, wrN, dataOeB, rdP, wrP, oe, wr;
  logic [3:0] modem_control_reg = 4'h0, pend = 4'h0, selN, irq, irqOeB;
  logic [2:0] addr, a;
  logic [7:0] dIn, dOut, rdData, q, d;
  logic [5:0] su;
  logic [1:0] ch;
  qhbp_access_t regAccess, seen;
  int fails = 0, n_tests = 0, nPulse = 0, expPulse = 0;
  wire irqAWire = irqOeB[0] ? 1'b1 : irq[0];
  // core stub: read byte made from channel and register
  function automatic logic [7:0] rdv(input logic [1:0] c, input logic [2:0] r);
    return {c, 3'h0, r} ^ 8'hA5;
  endfunction
  assign rdData = rdv(regAccess.chan, regAccess.addr);
  qhbp_host_port dut (.clk(clk), .rst_b(rst_b),
    .busModeStrobe(busModeStrobe), .readStrobeN(rdN), .writeStrobeN(wrN),
    .chanASelectN(selN[0]), .chanBSelectN(selN[1]), .chanCSelectN(selN[2]),
    .chanDSelectN(selN[3]), .addr(addr), .hostWrData(dIn),
    .hostRdData(dOut),
    .dataOeB(dataOeB), .irqForceEnable(irqForce), .modemCtrlIrqEn(modem_control_reg),
    .chanIrqPending(pend), .chanIrq(irq), .chanIrqOeB(irqOeB),
    .regAccess(regAccess), .regRdPulse(rdP), .regWrPulse(wrP),
    .regRdData(rdData));
  qhbp_host_model host (.clk(clk), .hostRdData(dOut), .dataOeB(dataOeB),
    .readStrobeN(rdN), .writeStrobeN(wrN), .selN(selN), .addr(addr),
    .hostWrData(dIn));
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  // record every register access pulse
  always @(posedge clk) begin
    if (rdP === 1'b1 || wrP === 1'b1) begin
      seen <= regAccess;
      nPulse <= nPulse + 1;
    end
  end
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // set irq inputs, check pins after the register delay
  task automatic irqChk(input logic [3:0] p, m, input logic f,
      input logic [3:0] lvl, eOe);
    pend = p;
    modem_control_reg = m;
    irqForce = f;
    repeat (2) @(posedge clk);
    #1 chk(irq === lvl && irqOeB === eOe, "irq pins");
    if (!busModeStrobe) begin
      chk(irqAWire === (|p ? 1'b0 : 1'b1), "device irq");
    end
  endtask
  // watchdog
  initial begin
    #100000;
    fails++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1 chk(dataOeB === 1'b1 && irqOeB === 4'hF, "reset");
    rst_b = 1'b1;
    @(posedge clk) #1;
    irqChk(4'h5, 4'h6, 1'b0, 4'h5, 4'h9);
    irqChk(4'hA, 4'h0, 1'b1, 4'hA, 4'h0);
    irqChk(4'h0, 4'h0, 1'b0, 4'h0, 4'hF);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        ch = 2'(i >> 1);
        wr = i[0];
        a = 3'(i + 2);
        d = 8'h3C + 8'(i);
        busModeStrobe = (m == 0);
        if (m == 0) begin
          su = {2'b11, ~(4'h1 << ch)};
          host.acc(su, {wr, ~wr, su[3:0]}, a, d, q, oe);
        end else begin
          su = {1'b1, ~wr, 1'b1, ch, 1'b1};
          host.acc(su, {su[5:1], 1'b0}, a, d, q, oe);
        end
        expPulse++;
        chk(nPulse === expPulse, "one pulse");
        chk({seen.write, seen.chan, seen.addr} === {wr, ch, a}, "acc");
        if (wr) begin
          chk(seen.data === d && oe === 1'b1, "write data");
        end else begin
          chk(q === rdv(ch, a) && oe === 1'b0, "read data");
        end
        chk(dataOeB === 1'b1, "bus released");
      end
    end
    // two selects at once are refused
    busModeStrobe = 1'b1;
    host.acc(6'h3C, 6'h1C, 3'h1, 8'h00, q, oe);
    chk(nPulse === expPulse && oe === 1'b1, "refused");
    busModeStrobe = 1'b0;
    irqChk(4'h0, 4'hF, 1'b0, 4'h0, 4'h1);
    irqChk(4'h8, 4'hF, 1'b0, 4'h0, 4'h0);
    // reset in mid-run floats every irq pin again
    rst_b = 1'b0;
    #1 chk(irqOeB === 4'hF && irq === 4'h0 && dataOeB === 1'b1, "rst2");
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk) #1;
    irqChk(4'h8, 4'hF, 1'b0, 4'h0, 4'h0);
    finish_test;
  end
endmodule
